// ==== rtl/glue_pkg.sv ====
/*
 * Shared constants, types and helpers for the board power and reset glue.
 * Assumes one 25 MHz reference clock and a synchronous active-high reset.
 */
// Overview of operation
// - Reset notify to I/O board asserts on probe reset or node reset-out low.
// - CPU test reset asserts only with power good and incoming test reset.
// - Fitted test-reset jumper asserts node test reset with power good, ignoring incoming test reset.
// - Node test reset never asserts without system power good.
// - Without jumper, node test reset follows power good AND incoming test reset.
// - Boot hub swap asserts when swap jumper or management swap request asserts.
// - While swap asserts, hub 2 acts as master 0 and hub 0 takes 2.
// - One active-low enable output per scale port turns that port on.
// - Both scale port enables stay off until system power good asserts.
// - A low scale port request turns that port off despite power good.
// - Glitch timer starts with a brief low pulse, then release; runs while high.
// - Low timer-done input means the glitch protection interval has elapsed.
// - Each of four CPUs gets its own active-low power good output.
// - Node power good asserts only when all node supply rails are good.
// - Memory power good asserts when the termination supply is valid.
// - Open-drain enable switches on node 3.3 V rail and its management bus segment.
// - Power path is plain gating, no sequencing state machine.
// - Spare 50 MHz clock input exists but nothing uses it.
// - Spare management input exists and has no function.
package glue_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned TIMER_PULSE_NS  = 1000;
    localparam int unsigned TIMER_PULSE_CYC = (TIMER_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 5;
    localparam int unsigned NUM_CPUS        = 4;
    localparam int unsigned NODE_RAILS      = 3;

    // Bit positions inside the synchronised input vector
    localparam int unsigned IN_PROBE_RST  = 0;
    localparam int unsigned IN_NODE_RST   = 1;
    localparam int unsigned IN_JTAG_RST   = 2;
    localparam int unsigned IN_TRST_JMP   = 3;
    localparam int unsigned IN_SWAP_JMP   = 4;
    localparam int unsigned IN_MGMT_SWAP  = 5;
    localparam int unsigned IN_SP0_REQ    = 6;
    localparam int unsigned IN_SP1_REQ    = 7;
    localparam int unsigned IN_SYS_OK     = 8;
    localparam int unsigned IN_TMR_DONE   = 9;
    localparam int unsigned IN_MEM_TERM   = 10;
    localparam int unsigned IN_RAIL_REQ   = 11;
    localparam int unsigned IN_CPU_POD    = 12;
    localparam int unsigned IN_NODE_RAIL  = 16;
    localparam int unsigned IN_W          = 19;

    // Inactive level of every input: active-low ones high, the rest low
    localparam logic [IN_W-1:0]  IN_RESET_VAL  = 19'h0023f;
    localparam logic [CNT_W-1:0] PULSE_RELOAD  = CNT_W'(TIMER_PULSE_CYC - 1);

    typedef enum logic [3:0] {
        T_IDLE  = 4'b0001,
        T_PULSE = 4'b0010,
        T_RUN   = 4'b0100,
        T_DONE  = 4'b1000
    } timer_state_t;

    function automatic logic jtagGate(input logic sysOk, input logic trstN);
        return sysOk & ~trstN;
    endfunction

endpackage

// ==== rtl/input_sync.sv ====
/*
 * Two-stage synchroniser for every pin input of the glue block except the two unused spare pins.
 * Assumes the pins are asynchronous to ref_clk; only stage two is read.
 */
`timescale 1ns/1ns
module input_sync
    import glue_pkg::*;
(
    input  wire logic            ref_clk, // 25 MHz clock
    input  wire logic            sys_rst, // synchronous reset
    input  wire logic [IN_W-1:0] pinIn,   // raw pins
    output logic      [IN_W-1:0] syncOut  // synchronised pins
);
    typedef struct packed {
        logic [IN_W-1:0] meta;
        logic [IN_W-1:0] stage;
    } sync_state_t;

    sync_state_t state_q;
    sync_state_t state_d;

    always_comb begin
        state_d       = state_q;
        state_d.meta  = pinIn;
        state_d.stage = state_q.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= '{meta: IN_RESET_VAL, stage: IN_RESET_VAL};
        end else begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stage;

endmodule // input_sync

// ==== rtl/glitch_timer_ctrl.sv ====
/*
 * Drives the open-drain start pulse of the external RC glitch timer.
 * Assumes timerDoneN is already synchronised to ref_clk.
 */
`timescale 1ns/1ns
module glitch_timer_ctrl
    import glue_pkg::*;
(
    input  wire logic ref_clk,    // 25 MHz clock
    input  wire logic sys_rst,    // synchronous reset
    input  wire logic restart,    // input activity, start a new interval
    input  wire logic timerDoneN, // synchronised timer expired, active low
    output logic      pulseOeN,   // open-drain enable, low while pulling low
    output logic      settled     // interval elapsed since last activity
);
    typedef struct packed {
        timer_state_t     st;
        logic [CNT_W-1:0] cnt;
        logic             pulseOeN;
        logic             settled;
    } timer_reg_t;

    timer_reg_t state_q;
    timer_reg_t state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q.st)
            T_IDLE: begin
                state_d.st  = T_PULSE;
                state_d.cnt = PULSE_RELOAD;
            end
            T_PULSE: begin
                if (state_q.cnt == '0) begin
                    state_d.st = T_RUN;
                end else begin
                    state_d.cnt = state_q.cnt - CNT_W'(1);
                end
            end
            T_RUN, T_DONE: begin
                if (restart) begin
                    state_d.st  = T_PULSE;
                    state_d.cnt = PULSE_RELOAD;
                end else if (!timerDoneN) begin
                    state_d.st = T_DONE;
                end
            end
            default: begin
                state_d.st = T_IDLE;
            end
        endcase
        state_d.pulseOeN = (state_d.st != T_PULSE);
        state_d.settled  = (state_d.st == T_DONE);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= '{st: T_IDLE, cnt: '0, pulseOeN: 1'b1, settled: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    assign pulseOeN = state_q.pulseOeN;
    assign settled  = state_q.settled;

    a_pulse_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(pulseOeN) |-> !pulseOeN [*8])
        else $error("timer start pulse too short");

endmodule // glitch_timer_ctrl

// ==== rtl/power_reset_glue.sv ====
/*
 * Board power-good, reset, test-reset, boot hub swap and scale port glue.
 * Assumes all inputs are pins from other boards and parts, asynchronous to
 * ref_clk; open-drain pins are resolved outside from the enable outputs.
 */
`timescale 1ns/1ns
module power_reset_glue
    import glue_pkg::*;
(
    input  wire logic                  ref_clk,                // 25 MHz clock
    input  wire logic                  sys_rst,                // synchronous reset
    input  wire logic                  spare_clock_in,         // unused board clock
    input  wire logic                  mgmt_spare_in,          // unused management pin
    input  wire logic                  probe_reset_n,          // debug probe hard reset
    input  wire logic                  node_reset_out_lvl_n,   // node controller reset out
    input  wire logic                  jtagResetInN,           // level-shifted test reset
    input  wire logic                  test_reset_jumper_n,    // test reset jumper fitted
    input  wire logic                  swap_jumper_n,          // boot hub swap jumper
    input  wire logic                  mgmt_boot_swap_req_n,   // management swap request
    input  wire logic                  scale_port0_req,        // management enables port 0
    input  wire logic                  scale_port1_req,        // management enables port 1
    input  wire logic                  system_power_ok,        // all system rails valid
    input  wire logic                  glitch_timer_done_n,    // RC timer expired
    input  wire logic                  memTermSupplyOk,        // termination supply valid
    input  wire logic                  nodeRailOnReq,          // sequencer wants node rail
    input  wire logic [NUM_CPUS-1:0]   cpuPodOk,               // per CPU supply good
    input  wire logic [NODE_RAILS-1:0] nodeRailOk,             // node controller rails good
    output logic                       hard_reset_notify_n,    // reset notify to I/O board
    output logic                       cpu1_power_ok_n,        // CPU 1 power good
    output logic                       cpu2_power_ok_n,        // CPU 2 power good
    output logic                       cpu3_power_ok_n,        // CPU 3 power good
    output logic                       cpu4_power_ok_n,        // CPU 4 power good
    output logic                       node_ctrl_power_ok_n,   // node controller power good
    output logic                       mem_term_power_ok_n,    // memory power good
    output logic                       scale_port0_on_n,       // port 0 present control
    output logic                       scale_port1_on_n,       // port 1 present control
    output logic                       cpu_test_reset_n,       // open-drain data, always low
    output logic                       cpu_test_reset_oe_n,    // low pulls CPU test reset
    output logic                       node_ctrl_test_reset_n, // open-drain data, always low
    output logic                       node_ctrl_test_oe_n,    // low pulls node test reset
    output logic                       boot_hub_swap_n,        // open-drain data, always low
    output logic                       boot_hub_swap_oe_n,     // low asserts the swap
    output logic                       node_ctrl_rail_enable,  // open-drain data, always low
    output logic                       node_ctrl_rail_oe_n,    // low holds the rail off
    output logic                       timerEnableN,           // open-drain data, always low
    output logic                       timerEnableOeN,         // low during start pulse
    output logic                       glitchGuardSettled      // inputs quiet for one interval
);

    // Registered outputs plus the previous input snapshot for activity detection
    typedef struct packed {
        logic [IN_W-1:0]     prevIn;
        logic                hardRstN;
        logic [NUM_CPUS-1:0] cpuOkN;
        logic                nodeOkN;
        logic                memOkN;
        logic                sp0OnN;
        logic                sp1OnN;
        logic                cpuTrstOeN;
        logic                nodeTrstOeN;
        logic                swapOeN;
        logic                railOeN;
    } glue_reg_t;

    localparam glue_reg_t GLUE_RESET = '{
        prevIn:      IN_RESET_VAL,
        hardRstN:    1'b1,
        cpuOkN:      '1,
        nodeOkN:     1'b1,
        memOkN:      1'b1,
        sp0OnN:      1'b1,
        sp1OnN:      1'b1,
        cpuTrstOeN:  1'b1,
        nodeTrstOeN: 1'b1,
        swapOeN:     1'b1,
        railOeN:     1'b0
    };

    glue_reg_t        state_q;
    glue_reg_t        state_d;
    logic [IN_W-1:0]  pinIn;
    logic [IN_W-1:0]  syncIn;
    logic             inputActivity;
    logic             timerPulseOeN;
    logic             timerSettled;

    // Named views of the synchronised pins
    logic                  probeRstN;
    logic                  nodeRstOutN;
    logic                  jtagRstN;
    logic                  trstJumperN;
    logic                  swapJumperN;
    logic                  mgmtSwapN;
    logic                  sp0Req;
    logic                  sp1Req;
    logic                  sysOk;
    logic                  timerDoneN;
    logic                  memTermOk;
    logic                  railReq;
    logic [NUM_CPUS-1:0]   podOk;
    logic [NODE_RAILS-1:0] railOk;

    // spare_clock_in and mgmt_spare_in are deliberately left unconnected
    assign pinIn = {nodeRailOk, cpuPodOk, nodeRailOnReq, memTermSupplyOk, glitch_timer_done_n,
                    system_power_ok, scale_port1_req, scale_port0_req, mgmt_boot_swap_req_n,
                    swap_jumper_n, test_reset_jumper_n, jtagResetInN, node_reset_out_lvl_n,
                    probe_reset_n};

    input_sync u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (pinIn),
        .syncOut (syncIn)
    );

    assign probeRstN   = syncIn[IN_PROBE_RST];
    assign nodeRstOutN = syncIn[IN_NODE_RST];
    assign jtagRstN    = syncIn[IN_JTAG_RST];
    assign trstJumperN = syncIn[IN_TRST_JMP];
    assign swapJumperN = syncIn[IN_SWAP_JMP];
    assign mgmtSwapN   = syncIn[IN_MGMT_SWAP];
    assign sp0Req      = syncIn[IN_SP0_REQ];
    assign sp1Req      = syncIn[IN_SP1_REQ];
    assign sysOk       = syncIn[IN_SYS_OK];
    assign timerDoneN  = syncIn[IN_TMR_DONE];
    assign memTermOk   = syncIn[IN_MEM_TERM];
    assign railReq     = syncIn[IN_RAIL_REQ];
    assign podOk       = syncIn[IN_CPU_POD +: NUM_CPUS];
    assign railOk      = syncIn[IN_NODE_RAIL +: NODE_RAILS];

    // Any change except the timer's own output restarts the glitch interval, unless a start pulse is still running
    assign inputActivity = |((syncIn ^ state_q.prevIn) & ~(IN_W'(1) << IN_TMR_DONE));

    glitch_timer_ctrl u_timer (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .restart    (inputActivity),
        .timerDoneN (timerDoneN),
        .pulseOeN   (timerPulseOeN),
        .settled    (timerSettled)
    );

    // Pure gating recomputed every cycle: nothing here holds a value between
    // input changes, the register only aligns outputs to the clock
    always_comb begin
        state_d        = state_q;
        state_d.prevIn = syncIn;
        state_d.hardRstN = probeRstN & nodeRstOutN;
        state_d.cpuOkN   = ~podOk;
        state_d.nodeOkN  = ~(&railOk);
        state_d.memOkN   = ~memTermOk;
        // Ports stay off until system power is good, and drop on a low request
        state_d.sp0OnN   = ~(sysOk & sp0Req);
        state_d.sp1OnN   = ~(sysOk & sp1Req);
        state_d.cpuTrstOeN = ~jtagGate(sysOk, jtagRstN);
        if (!trstJumperN) begin
            state_d.nodeTrstOeN = ~sysOk;
        end else begin
            state_d.nodeTrstOeN = ~jtagGate(sysOk, jtagRstN);
        end
        // Held exactly as long as either source holds its request
        state_d.swapOeN  = swapJumperN & mgmtSwapN;
        // Released high switches on the 3.3 V rail and its bus segment
        state_d.railOeN  = railReq;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= GLUE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign hard_reset_notify_n    = state_q.hardRstN;
    assign cpu1_power_ok_n        = state_q.cpuOkN[0];
    assign cpu2_power_ok_n        = state_q.cpuOkN[1];
    assign cpu3_power_ok_n        = state_q.cpuOkN[2];
    assign cpu4_power_ok_n        = state_q.cpuOkN[3];
    assign node_ctrl_power_ok_n   = state_q.nodeOkN;
    assign mem_term_power_ok_n    = state_q.memOkN;
    assign scale_port0_on_n       = state_q.sp0OnN;
    assign scale_port1_on_n       = state_q.sp1OnN;
    // Open-drain pins only ever pull low; the enable decides the level
    assign cpu_test_reset_n       = 1'b0;
    assign cpu_test_reset_oe_n    = state_q.cpuTrstOeN;
    assign node_ctrl_test_reset_n = 1'b0;
    assign node_ctrl_test_oe_n    = state_q.nodeTrstOeN;
    assign boot_hub_swap_n        = 1'b0;
    assign boot_hub_swap_oe_n     = state_q.swapOeN;
    assign node_ctrl_rail_enable  = 1'b0;
    assign node_ctrl_rail_oe_n    = state_q.railOeN;
    assign timerEnableN           = 1'b0;
    assign timerEnableOeN         = timerPulseOeN;
    // Settled is advisory; outputs above do not wait on it, so a slow edge can
    // still reach them for one cycle
    assign glitchGuardSettled     = timerSettled;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_reset_notify: assert property (
        hard_reset_notify_n == $past(probeRstN & nodeRstOutN))
        else $error("reset notify does not follow probe or node reset");

    a_probe_notify: assert property (
        !probeRstN |=> !hard_reset_notify_n)
        else $error("probe reset not forwarded");

    a_cpu_trst_gate: assert property (
        !cpu_test_reset_oe_n |-> $past(sysOk) && !$past(jtagRstN))
        else $error("CPU test reset without power good and test reset");

    a_cpu_trst_on: assert property (
        (sysOk && !jtagRstN) |=> !cpu_test_reset_oe_n)
        else $error("CPU test reset missing");

    a_jumper_trst: assert property (
        (!trstJumperN && sysOk && jtagRstN) |=> !node_ctrl_test_oe_n)
        else $error("jumper did not force node test reset");

    a_node_trst_pwr: assert property (
        !sysOk |=> node_ctrl_test_oe_n)
        else $error("node test reset without power good");

    a_node_cpu_match: assert property (
        $past(trstJumperN) |-> node_ctrl_test_oe_n == cpu_test_reset_oe_n)
        else $error("node test reset differs from CPU with jumper out");

    a_swap_follow: assert property (
        boot_hub_swap_oe_n == $past(swapJumperN & mgmtSwapN))
        else $error("boot hub swap wrong");

    a_port_pwr_off: assert property (
        !sysOk |=> scale_port0_on_n && scale_port1_on_n)
        else $error("scale port on before power good");

    a_port_req_off: assert property (
        (!sp0Req ##0 !sp1Req) |=> scale_port0_on_n && scale_port1_on_n)
        else $error("scale port on without request");

    a_port_on: assert property (
        (sysOk && sp0Req) |=> !scale_port0_on_n)
        else $error("scale port 0 not enabled");

    a_cpu_pwr_good: assert property (
        cpu1_power_ok_n == !$past(podOk[0]) && cpu4_power_ok_n == !$past(podOk[3]))
        else $error("CPU power good wrong");

    a_node_rails: assert property (
        !node_ctrl_power_ok_n |-> &$past(railOk))
        else $error("node power good with a rail down");

    a_mem_term: assert property (
        mem_term_power_ok_n == !$past(memTermOk))
        else $error("memory power good wrong");

    a_rail_enable: assert property (
        railReq |=> node_ctrl_rail_oe_n)
        else $error("node rail not released");

    // Activity during a running pulse is ignored, so only a released enable must restart
    a_timer_restart: assert property (
        (inputActivity && timerEnableOeN) |=> !timerEnableOeN)
        else $error("activity did not restart glitch timer");

    c_probe_reset:  cover property (!probeRstN ##1 !hard_reset_notify_n);
    c_jumper_trst:  cover property (!trstJumperN && sysOk ##1 !node_ctrl_test_oe_n);
    c_swap_mgmt:    cover property (!mgmtSwapN ##1 !boot_hub_swap_oe_n);
    c_port_drop:    cover property (!scale_port0_on_n ##1 sysOk && !sp0Req ##1 scale_port0_on_n);
    c_timer_settle: cover property ($rose(glitchGuardSettled));

endmodule // power_reset_glue

// ==== sim/board_far_side.sv ====
/*
 * Far-side model: pull-ups on the open-drain pins and the external RC glitch timer.
 * Assumes the glue drives each open-drain pin as a data/enable pair, enable active low.
 */
`timescale 1ns/1ns
module board_far_side (
    input  wire logic ref_clk,   // board clock, used only to time the RC model
    input  wire logic tmrData,   // timer enable data
    input  wire logic tmrOeN,    // low pulls the timer enable pin
    input  wire logic cpuData,   // cpu test reset data
    input  wire logic cpuOeN,    // low pulls cpu test reset
    input  wire logic nodeData,  // node test reset data
    input  wire logic nodeOeN,   // low pulls node test reset
    input  wire logic swapData,  // boot hub swap data
    input  wire logic swapOeN,   // low pulls boot hub swap
    input  wire logic railData,  // rail enable data
    input  wire logic railOeN,   // low holds the rail off
    output logic      timerDoneN, // RC timer expired, active low
    output logic      cpuLine,    // resolved cpu test reset pin
    output logic      nodeLine,   // resolved node test reset pin
    output logic      swapLine,   // resolved swap pin
    output logic      railLine    // resolved rail enable pin
);
    // Longer than the start pulse so an early expiry would show up as a fault
    localparam int RC_CYCLES = 40;
    int   rcCount = 0;
    logic tmrLine;
    // Released pins float to the pull-up level
    assign tmrLine  = tmrOeN ? 1'b1 : tmrData;
    assign cpuLine  = cpuOeN ? 1'b1 : cpuData;
    assign nodeLine = nodeOeN ? 1'b1 : nodeData;
    assign swapLine = swapOeN ? 1'b1 : swapData;
    assign railLine = railOeN ? 1'b1 : railData;
    always @(posedge ref_clk) begin
        if (!tmrLine)
            rcCount <= 0;
        else if (rcCount < RC_CYCLES)
            rcCount <= rcCount + 1;
    end
    assign timerDoneN = (rcCount == RC_CYCLES) ? 1'b0 : 1'b1;
endmodule // board_far_side

// ==== sim/testbench.sv ====
/*
 * Self-checking bench for the power and reset glue.
 * Assumes a three-edge pin-to-output latency and open-drain pins with pull-ups.
 */
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    import glue_pkg::*;
    logic ref_clk = 0, sys_rst = 1, spareClk = 0, spareIn = 0, probeN = 1, nodeRstN = 1, jtagN = 1;
    logic trstJmpN = 1, swapJmpN = 1, mgmtSwapN = 1, sp0 = 0, sp1 = 0, sysOk = 0, memOk = 0, railReq = 0;
    logic [NUM_CPUS-1:0] pod = '0;
    logic [NODE_RAILS-1:0] rails = '0;
    wire [3:0] cpuOkN;
    logic notifyN, nodeOkN, memOkN, sp0OnN, sp1OnN, cpuTd, cpuOe, ndTd, ndOe, swTd, swOe, rlTd, rlOe;
    logic tmrTd, tmrOe, settled, doneN, cpuLine, nodeLine, swapLine, railLine;
    int n_mismatch = 0, checks_done = 0, cycles = 0, n;

    always #20 ref_clk = ~ref_clk;

    power_reset_glue i_power_reset_glue (.ref_clk(ref_clk), .sys_rst(sys_rst), .spare_clock_in(spareClk),
        .mgmt_spare_in(spareIn), .probe_reset_n(probeN), .node_reset_out_lvl_n(nodeRstN), .jtagResetInN(jtagN),
        .test_reset_jumper_n(trstJmpN), .swap_jumper_n(swapJmpN), .mgmt_boot_swap_req_n(mgmtSwapN),
        .scale_port0_req(sp0), .scale_port1_req(sp1), .system_power_ok(sysOk), .glitch_timer_done_n(doneN),
        .memTermSupplyOk(memOk), .nodeRailOnReq(railReq), .cpuPodOk(pod), .nodeRailOk(rails),
        .hard_reset_notify_n(notifyN), .cpu1_power_ok_n(cpuOkN[0]), .cpu2_power_ok_n(cpuOkN[1]),
        .cpu3_power_ok_n(cpuOkN[2]), .cpu4_power_ok_n(cpuOkN[3]), .node_ctrl_power_ok_n(nodeOkN),
        .mem_term_power_ok_n(memOkN), .scale_port0_on_n(sp0OnN), .scale_port1_on_n(sp1OnN),
        .cpu_test_reset_n(cpuTd), .cpu_test_reset_oe_n(cpuOe), .node_ctrl_test_reset_n(ndTd),
        .node_ctrl_test_oe_n(ndOe), .boot_hub_swap_n(swTd), .boot_hub_swap_oe_n(swOe),
        .node_ctrl_rail_enable(rlTd), .node_ctrl_rail_oe_n(rlOe), .timerEnableN(tmrTd),
        .timerEnableOeN(tmrOe), .glitchGuardSettled(settled));

    board_far_side i_board_far_side (.ref_clk(ref_clk), .tmrData(tmrTd), .tmrOeN(tmrOe), .cpuData(cpuTd),
        .cpuOeN(cpuOe), .nodeData(ndTd), .nodeOeN(ndOe), .swapData(swTd), .swapOeN(swOe), .railData(rlTd),
        .railOeN(rlOe), .timerDoneN(doneN), .cpuLine(cpuLine), .nodeLine(nodeLine), .swapLine(swapLine),
        .railLine(railLine));

    task automatic final_report();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard: whole run needs well under 3000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #2;
    endtask

    task automatic check_idle();
        `CHK({notifyN, cpuOkN, nodeOkN, memOkN, sp0OnN, sp1OnN, cpuLine, nodeLine, swapLine}, 12'hfff)
        `CHK(rlOe, 1'b0)
    endtask

    task automatic check_reset_notify();
        for (int i = 0; i < 4; i++) begin
            step();
            probeN = i[0];
            nodeRstN = i[1];
            settle();
            `CHK(notifyN, probeN & nodeRstN)
        end
    endtask

    task automatic check_test_reset();
        for (int i = 0; i < 8; i++) begin
            step();
            sysOk = i[0];
            jtagN = i[1];
            trstJmpN = i[2];
            settle();
            `CHK(cpuLine, ~(sysOk & ~jtagN))
            `CHK(nodeLine, ~(sysOk & (~trstJmpN | ~jtagN)))
        end
    endtask

    task automatic check_swap_and_ports();
        for (int i = 0; i < 8; i++) begin
            step();
            swapJmpN = i[0];
            mgmtSwapN = i[1];
            sp0 = i[0];
            sp1 = i[1];
            sysOk = i[2];
            settle();
            `CHK(swapLine, swapJmpN & mgmtSwapN)
            `CHK({sp1OnN, sp0OnN}, ~({sp1, sp0} & {2{sysOk}}))
        end
    endtask

    task automatic check_power_goods();
        for (int i = 0; i < 8; i++) begin
            step();
            pod = 4'h1 << (i % 4);
            rails = (i == 7) ? 3'h7 : 3'(i);
            memOk = i[0];
            railReq = i[1];
            spareIn = i[2];
            spareClk = i[0];
            settle();
            `CHK(cpuOkN, ~pod)
            `CHK(nodeOkN, ~&rails)
            `CHK(memOkN, ~memOk)
            `CHK(railLine, railReq)
        end
    endtask

    task automatic check_glitch_timer();
        n = 0;
        while (settled !== 1'b1 && n < 300) begin
            step();
            n++;
        end
        `CHK(settled, 1'b1)
        step();
        memOk = ~memOk;
        n = 0;
        while (tmrOe !== 1'b0 && n < 8) begin
            step();
            n++;
        end
        n = 0;
        while (tmrOe === 1'b0 && n < 100) begin
            step();
            n++;
        end
        `CHK(n, int'(TIMER_PULSE_CYC))
        n = 0;
        while (settled !== 1'b1 && n < 100) begin
            step();
            n++;
        end
        `CHK(settled, 1'b1)
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        sys_rst = 0;
        settle();
        check_idle();
        check_reset_notify();
        check_test_reset();
        check_swap_and_ports();
        check_power_goods();
        check_glitch_timer();
        final_report();
    end
endmodule // testbench
